/* design/acdpc_top.sv */
`timescale 1ns/1ns
module acdpc_top #(
	parameter int DATA_WIDTH  = acdpc_pkg::DATA_W,
	parameter int WAKE_WIDTH  = acdpc_pkg::WAKE_W,
	parameter int DCS_PERIOD  = acdpc_pkg::DCS_MAX_PERIOD
) (
	input  wire logic                            REF_CLK,
	input  wire logic                            RST,
	input  wire logic                            SAMPLE_CLK_PIN,
	input  wire logic                            SYNC_PIN,
	input  wire logic                            POWER_DOWN_PIN,
	input  wire logic                            SERIAL_CLOCK_FORMAT_STRAP,
	input  wire logic                            SERIAL_DATA_STABILIZER_STRAP,
	input  wire logic                            SERIAL_MODE,
	input  wire logic                            REG_WR,
	input  wire logic [acdpc_pkg::ADDR_W-1:0]    REG_ADDR,
	input  wire logic [7:0]                      REG_WDATA,
	output logic      [7:0]                      REG_RDATA,
	input  wire logic                            CFG_POWER_DOWN,
	input  wire logic                            CFG_STANDBY,
	input  wire acdpc_pkg::acdpc_fmt_t           CFG_FORMAT,
	input  wire logic                            CFG_DCS_EN,
	input  wire logic [acdpc_pkg::DIV_W-1:0]     CFG_DIV_RATIO,
	input  wire logic [DATA_WIDTH-1:0]           CORE_DATA,
	output logic      [DATA_WIDTH-1:0]           DATA_OUT,
	output logic                                 DATA_OE_N,
	output logic                                 INT_CLK,
	output logic                                 DCS_ACTIVE,
	output logic                                 DCS_LOCKED,
	output logic                                 REF_ON,
	output logic                                 BIAS_ON,
	output logic                                 CLK_RUN,
	output logic                                 WAKE_BUSY
);
	import acdpc_pkg::*;

	typedef struct packed {
		logic [2:0]            clk_sync;
		logic [2:0]            sync_sync;
		logic [1:0]            pd_sync;
		logic [1:0]            fmt_sync;
		logic [1:0]            dcs_sync;
		logic [7:0]            ctrl;
		logic                  armed;
		logic [DIV_W-1:0]      div_cnt;
		logic                  div_clk;
		acdpc_pwr_t            pwr;
		logic [WAKE_WIDTH-1:0] down_time;
		logic [WAKE_WIDTH-1:0] wake_cnt;
		logic [7:0]            rdata;
		logic [DATA_WIDTH-1:0] dout;
		logic                  oe_n;
		logic                  int_clk;
		logic                  dcs_act;
		logic                  dcs_lock;
		logic                  ref_on;
		logic                  bias_on;
		logic                  clk_run;
		logic                  wake_busy;
	} acdpc_state_t;

	acdpc_state_t s_reg;
	acdpc_state_t s_next;

	localparam logic [DIV_W-1:0]      DIV_ONE  = 3'h1;
	localparam logic [WAKE_WIDTH-1:0] WAKE_ONE = WAKE_WIDTH'(1);
	localparam logic [WAKE_WIDTH-1:0] WAKE_MAX = '1;

	// reset image: everything off except power domains and drivers
	function automatic acdpc_state_t reset_image();
		acdpc_state_t r;
		r         = '0;
		r.ctrl    = DIV_SYNC_RESET;
		r.pwr     = PW_ACTIVE;
		r.oe_n    = 1'b0;
		r.ref_on  = 1'b1;
		r.bias_on = 1'b1;
		r.clk_run = 1'b1;
		return r;
	endfunction

	localparam acdpc_state_t RESET_STATE = reset_image();

	logic                  raw_rise;
	logic                  sync_edge;
	logic                  sync_take;
	logic                  pd_req;
	logic                  dcs_want;
	logic                  dcs_on;
	logic                  dcs_clk;
	logic                  dcs_lock;
	logic                  reg_hit;
	logic                  wr_hit;
	logic                  sb_req;
	acdpc_fmt_t            fmt;
	logic [DATA_WIDTH-1:0] word;
	logic [DATA_WIDTH-1:0] gray_word;

	acdpc_dcs #(
		.MAX_PERIOD (DCS_PERIOD)
	) u_dcs (
		.clk     (REF_CLK),
		.rst     (RST),
		.clk_in  (s_reg.div_clk),
		.enable  (dcs_on),
		.clk_out (dcs_clk),
		.locked  (dcs_lock)
	);

	// each gray bit below the top is a bit against its upper neighbour; the top bit passes through
	for (genvar b = 0; b < DATA_WIDTH - 1; b++) begin : g_gray
		assign gray_word[b] = CORE_DATA[b] ^ CORE_DATA[b+1];
	end
	assign gray_word[DATA_WIDTH-1] = CORE_DATA[DATA_WIDTH-1];

	always_comb begin
		s_next = s_reg;

		// pins pass two flops before use; stage 0 feeds stage 1 only
		s_next.clk_sync  = {s_reg.clk_sync[1:0], SAMPLE_CLK_PIN};
		s_next.sync_sync = {s_reg.sync_sync[1:0], SYNC_PIN};
		s_next.pd_sync   = {s_reg.pd_sync[0], POWER_DOWN_PIN};
		s_next.fmt_sync  = {s_reg.fmt_sync[0], SERIAL_CLOCK_FORMAT_STRAP};
		s_next.dcs_sync  = {s_reg.dcs_sync[0],
			SERIAL_DATA_STABILIZER_STRAP};

		raw_rise  = s_reg.clk_sync[1] & ~s_reg.clk_sync[2];
		sync_edge = s_reg.sync_sync[1] & ~s_reg.sync_sync[2];

		// sync mode: every pulse, or only the first after a write
		sync_take = sync_edge && s_reg.ctrl[SYNC_EVERY_BIT]
			&& (!s_reg.ctrl[SYNC_ONCE_BIT] || s_reg.armed);

		// register port
		reg_hit = REG_ADDR == DIV_SYNC_ADDR;
		wr_hit  = REG_WR && reg_hit;
		if (sync_take && s_reg.ctrl[SYNC_ONCE_BIT]) begin
			s_next.armed = 1'b0;
		end
		if (wr_hit) begin
			s_next.ctrl = REG_WDATA & DIV_SYNC_WMASK;
			// a write re-arms even if a pulse is taken this same cycle
			s_next.armed = 1'b1;
		end
		// read data is registered, so it trails the address by a cycle
		s_next.rdata = 8'h00;
		if (reg_hit) begin
			s_next.rdata = s_reg.ctrl;
			s_next.rdata[SYNC_ARMED_BIT] = s_reg.armed;
		end

		// power control: serial bit or pin, pin low releases
		pd_req = CFG_POWER_DOWN | s_reg.pd_sync[1];
		// standby only exists on the serial port
		sb_req = SERIAL_MODE && CFG_STANDBY;
		case (s_reg.pwr)
			PW_ACTIVE: begin
				if (pd_req) begin
					s_next.pwr = PW_DOWN;
					s_next.down_time = '0;
				end else if (sb_req) begin
					s_next.pwr = PW_STANDBY;
					s_next.down_time = '0;
				end
			end
			PW_STANDBY: begin
				if (s_reg.down_time != WAKE_MAX) begin
					s_next.down_time = s_reg.down_time + WAKE_ONE;
				end
				if (pd_req) begin
					s_next.pwr = PW_DOWN;
				end else if (!sb_req) begin
					// reference stayed up, so only a fraction is needed
					s_next.pwr = PW_WAKE;
					s_next.wake_cnt = s_reg.down_time
						>> STANDBY_SHIFT;
				end
			end
			PW_DOWN: begin
				if (s_reg.down_time != WAKE_MAX) begin
					s_next.down_time = s_reg.down_time + WAKE_ONE;
				end
				if (!pd_req) begin
					// recovery tracks the time spent down
					s_next.pwr = PW_WAKE;
					s_next.wake_cnt = s_reg.down_time;
				end
			end
			PW_WAKE: begin
				if (pd_req) begin
					// charge regained so far is kept for the next exit
					s_next.pwr = PW_DOWN;
					s_next.down_time = s_reg.wake_cnt;
				end else if (s_reg.wake_cnt == '0) begin
					s_next.pwr = PW_ACTIVE;
				end else begin
					s_next.wake_cnt = s_reg.wake_cnt - WAKE_ONE;
				end
			end
			default: begin
				s_next.pwr = PW_DOWN;
			end
		endcase

		// reference stays up in standby; bias and clock stop, drivers and data stay on
		case (s_next.pwr)
			PW_ACTIVE: begin
				s_next.ref_on    = 1'b1;
				s_next.bias_on   = 1'b1;
				s_next.clk_run   = 1'b1;
				s_next.wake_busy = 1'b0;
			end
			PW_WAKE: begin
				s_next.ref_on    = 1'b1;
				s_next.bias_on   = 1'b1;
				s_next.clk_run   = 1'b0;
				s_next.wake_busy = 1'b1;
			end
			PW_STANDBY: begin
				s_next.ref_on    = 1'b1;
				s_next.bias_on   = 1'b0;
				s_next.clk_run   = 1'b0;
				s_next.wake_busy = 1'b0;
			end
			default: begin
				// full power-down: reference, buffer, bias and clock off
				s_next.ref_on    = 1'b0;
				s_next.bias_on   = 1'b0;
				s_next.clk_run   = 1'b0;
				s_next.wake_busy = 1'b0;
			end
		endcase

		// integer divider on the raw sample clock
		// a ratio lowered mid-count wraps at once instead of running on
		if (s_reg.pwr != PW_ACTIVE) begin
			s_next.div_cnt = '0;
			s_next.div_clk = 1'b0;
		end else begin
			if (sync_take) begin
				s_next.div_cnt = '0;
			end else if (raw_rise) begin
				s_next.div_cnt = (s_reg.div_cnt >= CFG_DIV_RATIO)
					? '0 : s_reg.div_cnt + DIV_ONE;
			end
			// output follows the raw high phase of the first input period
			s_next.div_clk = s_reg.clk_sync[1]
				&& (raw_rise ? s_next.div_cnt == '0
					: s_reg.div_cnt == '0);
		end

		// stabilizer enable: strap or serial, forced by division
		if (SERIAL_MODE) begin
			dcs_want = CFG_DCS_EN;
		end else begin
			dcs_want = s_reg.dcs_sync[1];
		end
		// division always needs the stabilizer, whatever the enable says
		dcs_on = dcs_want || CFG_DIV_RATIO != DIV_BY_ONE;
		s_next.dcs_act  = dcs_on;
		s_next.dcs_lock = dcs_lock;
		// unlocked loop is bypassed inside the stabilizer
		if (s_reg.pwr != PW_ACTIVE) begin
			s_next.int_clk = 1'b0;
		end else if (dcs_on) begin
			s_next.int_clk = dcs_clk;
		end else begin
			s_next.int_clk = s_reg.div_clk;
		end

		// output coding
		if (SERIAL_MODE) begin
			fmt = CFG_FORMAT;
		end else if (s_reg.fmt_sync[1]) begin
			fmt = FMT_TWOS;
		end else begin
			fmt = FMT_OFFSET;
		end
		case (fmt)
			FMT_TWOS: begin
				// mid-scale 10..0 becomes 00..0
				word = {~CORE_DATA[DATA_WIDTH-1],
					CORE_DATA[DATA_WIDTH-2:0]};
			end
			FMT_GRAY: begin
				word = gray_word;
			end
			FMT_OFFSET: begin
				word = CORE_DATA;
			end
			default: begin
				// unused code 3 falls back to offset binary
				word = CORE_DATA;
			end
		endcase
		s_next.dout = word;
		// drivers released only in full power-down, not in standby or wake-up
		s_next.oe_n = s_next.pwr == PW_DOWN;
		if (s_next.oe_n) begin
			s_next.dout = '0;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s_reg <= RESET_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign REG_RDATA  = s_reg.rdata;
	assign DATA_OUT   = s_reg.dout;
	assign DATA_OE_N  = s_reg.oe_n;
	assign INT_CLK    = s_reg.int_clk;
	assign DCS_ACTIVE = s_reg.dcs_act;
	assign DCS_LOCKED = s_reg.dcs_lock;
	assign REF_ON     = s_reg.ref_on;
	assign BIAS_ON    = s_reg.bias_on;
	assign CLK_RUN    = s_reg.clk_run;
	assign WAKE_BUSY  = s_reg.wake_busy;

endmodule

/* design/acdpc_pkg.sv */
package acdpc_pkg;

	// register map of the divider/sync control
	localparam int              ADDR_W          = 13;
	localparam logic [12:0]     DIV_SYNC_ADDR   = 13'h100;
	localparam logic [7:0]      DIV_SYNC_RESET  = 8'h00;
	localparam logic [7:0]      DIV_SYNC_WMASK  = 8'h06;
	localparam int              SYNC_EVERY_BIT  = 1;
	localparam int              SYNC_ONCE_BIT   = 2;
	localparam int              SYNC_ARMED_BIT  = 3;

	// divider: field holds ratio minus one, so 0..7 means 1..8
	localparam int              DIV_W           = 3;
	localparam logic [2:0]      DIV_BY_ONE      = 3'h0;

	// stabilizer lower rate limit against the reference clock
	localparam int              CLK_FREQ_MHZ    = 125;
	localparam int              DCS_MIN_MHZ     = 20;
	localparam int              DCS_MAX_PERIOD  = CLK_FREQ_MHZ / DCS_MIN_MHZ;
	localparam int              PER_W           = 8;

	// output word
	localparam int              DATA_W          = 14;

	// wake-up scaling: standby keeps the reference up, so it recovers faster
	localparam int              WAKE_W          = 16;
	localparam int              STANDBY_SHIFT   = 3;

	typedef enum logic [1:0] {
		FMT_OFFSET,
		FMT_TWOS,
		FMT_GRAY
	} acdpc_fmt_t;

	typedef enum logic [1:0] {
		PW_ACTIVE,
		PW_STANDBY,
		PW_DOWN,
		PW_WAKE
	} acdpc_pwr_t;

endpackage

/* design/acdpc_dcs.sv */
`timescale 1ns/1ns
module acdpc_dcs #(
	parameter int MAX_PERIOD = acdpc_pkg::DCS_MAX_PERIOD
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clk_in,
	input  wire logic enable,
	output logic      clk_out,
	output logic      locked
);
	import acdpc_pkg::*;

	typedef struct packed {
		logic             prev;
		logic [PER_W-1:0] per_cnt;
		logic [PER_W-1:0] last_per;
		logic [PER_W-1:0] hi_cnt;
		logic             locked;
		logic             out;
	} acdpc_dcs_t;

	acdpc_dcs_t s_reg;
	acdpc_dcs_t s_next;

	localparam logic [PER_W-1:0] MAX_P = PER_W'(MAX_PERIOD);
	localparam logic [PER_W-1:0] ONE   = 8'h01;

	logic             rise;
	logic [PER_W-1:0] half;

	always_comb begin
		s_next = s_reg;
		rise = clk_in & ~s_reg.prev;
		half = (s_reg.last_per >> 1) | ONE;
		s_next.prev = clk_in;
		if (s_reg.per_cnt != 8'hFF) begin
			s_next.per_cnt = s_reg.per_cnt + ONE;
		end
		if (s_reg.hi_cnt != 8'hFF) begin
			s_next.hi_cnt = s_reg.hi_cnt + ONE;
		end
		if (rise) begin
			s_next.per_cnt = ONE;
			s_next.hi_cnt = ONE;
			s_next.last_per = s_reg.per_cnt;
			// lock needs two equal periods inside the working rate
			s_next.locked = enable && s_reg.per_cnt == s_reg.last_per
				&& s_reg.per_cnt <= MAX_P;
		end else if (s_reg.per_cnt > MAX_P || !enable) begin
			s_next.locked = 1'b0;
		end
		if (s_reg.locked && enable) begin
			// rising edge kept, falling edge placed at half period
			s_next.out = rise | (s_reg.out && s_reg.hi_cnt < half);
		end else begin
			s_next.out = clk_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign clk_out = s_reg.out;
	assign locked  = s_reg.locked;

endmodule

/* tb/acdpc_assertions.sv */
`timescale 1ns/1ns
module acdpc_assertions #(
	parameter int DATA_WIDTH = acdpc_pkg::DATA_W
) (
	input wire logic                  REF_CLK,
	input wire logic                  RST,
	input wire logic                  SERIAL_MODE,
	input wire logic [12:0]           REG_ADDR,
	input wire logic [7:0]            REG_RDATA,
	input wire logic                  CFG_POWER_DOWN,
	input wire acdpc_pkg::acdpc_fmt_t CFG_FORMAT,
	input wire logic [2:0]            CFG_DIV_RATIO,
	input wire logic [DATA_WIDTH-1:0] CORE_DATA,
	input wire logic [DATA_WIDTH-1:0] DATA_OUT,
	input wire logic                  DATA_OE_N,
	input wire logic                  DCS_ACTIVE,
	input wire logic                  DCS_LOCKED,
	input wire logic                  REF_ON,
	input wire logic                  BIAS_ON,
	input wire logic                  CLK_RUN,
	input wire logic                  WAKE_BUSY
);
	import acdpc_pkg::*;
	localparam logic [DATA_WIDTH-1:0] TOP = {1'b1, {(DATA_WIDTH-1){1'b0}}};
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	AST_DOWN_OFF: assert property (DATA_OE_N |->
		DATA_OUT == '0 && !REF_ON && !BIAS_ON && !CLK_RUN)
		else $error("power-down left a domain running");
	AST_PD_ENTER: assert property (CFG_POWER_DOWN && CLK_RUN |=>
		DATA_OE_N) else $error("serial power-down not entered");
	AST_WAKE: assert property ($fell(DATA_OE_N) |->
		WAKE_BUSY && BIAS_ON && !CLK_RUN) else $error("no wake-up phase");
	AST_FORCE: assert property (CFG_DIV_RATIO != DIV_BY_ONE |=>
		DCS_ACTIVE) else $error("divider did not force stabilizer");
	// lock flag trails the enable by two stages and DCS_ACTIVE by one, so four idle cycles leave margin
	AST_BYPASS: assert property (!DCS_ACTIVE [*4] |-> !DCS_LOCKED)
		else $error("locked while stabilizer off");
	AST_TWOS: assert property ((SERIAL_MODE &&
		CFG_FORMAT == FMT_TWOS && !DATA_OE_N) [*3] ##1 !DATA_OE_N |->
		DATA_OUT == ($past(CORE_DATA) ^ TOP)) else $error("bad twos word");
	AST_GRAY: assert property ((SERIAL_MODE &&
		CFG_FORMAT == FMT_GRAY && !DATA_OE_N) [*3] ##1 !DATA_OE_N |->
		DATA_OUT == ($past(CORE_DATA) ^ ($past(CORE_DATA) >> 1)))
		else $error("bad gray word");
	AST_RD_MISS: assert property (REG_ADDR != DIV_SYNC_ADDR |=>
		REG_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule

/* tb/acdpc_src.sv */
`timescale 1ns/1ns
module acdpc_src (
	input var int per,
	input var int hi,
	output logic  clk_o
);
	// edges sit 1 ns before a reference edge so sync latency is fixed
	initial begin
		clk_o = 1'b0;
		#3;
		forever begin
			clk_o = 1'b1;
			#(hi * 8);
			clk_o = 1'b0;
			#((per - hi) * 8);
		end
	end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import acdpc_pkg::*;
	logic        ref_clk = 1'b0, rst = 1'b1, raw, syn = 1'b0, pd = 1'b0;
	logic        fmt_s = 1'b0, dcs_s = 1'b1, ser = 1'b1, wr = 1'b0;
	logic        cfg_pd = 1'b0, cfg_sb = 1'b0, dcs_en = 1'b0, rnd = 1'b1;
	logic        oe_n, iclk, dact, lock, ref_on, bias_on, clk_run, busy;
	logic [12:0] addr = 13'h100;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [2:0]  ratio = 3'h0;
	logic [13:0] core = 14'h0000, dout;
	logic [15:0] t, d1, d2, w1, w2;
	acdpc_fmt_t  fmt = FMT_OFFSET;
	int          per = 6, hi = 2, n_errors = 0, n_compared = 0, cyc = 0;
	always #4 ref_clk = ~ref_clk;
	acdpc_top #(.WAKE_WIDTH(8)) i_acdpc_top (
		.REF_CLK(ref_clk), .RST(rst), .SAMPLE_CLK_PIN(raw), .SYNC_PIN(syn),
		.POWER_DOWN_PIN(pd), .SERIAL_CLOCK_FORMAT_STRAP(fmt_s),
		.SERIAL_DATA_STABILIZER_STRAP(dcs_s), .SERIAL_MODE(ser),
		.REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.CFG_POWER_DOWN(cfg_pd), .CFG_STANDBY(cfg_sb), .CFG_FORMAT(fmt),
		.CFG_DCS_EN(dcs_en), .CFG_DIV_RATIO(ratio), .CORE_DATA(core),
		.DATA_OUT(dout), .DATA_OE_N(oe_n), .INT_CLK(iclk),
		.DCS_ACTIVE(dact), .DCS_LOCKED(lock), .REF_ON(ref_on),
		.BIAS_ON(bias_on), .CLK_RUN(clk_run), .WAKE_BUSY(busy));
	acdpc_src i_acdpc_src (.per(per), .hi(hi), .clk_o(raw));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc_n(1);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [12:0] a, input logic [7:0] e);
		addr = a;
		cyc_n(2);
		chk(16'(rdata), 16'(e));
	endtask
	task automatic rise(output logic [15:0] n);
		n = 0;
		while (iclk !== 1'b0 && n < 400) begin
			cyc_n(1);
			n++;
		end
		while (iclk !== 1'b1 && n < 400) begin
			cyc_n(1);
			n++;
		end
	endtask
	task automatic hi_len(output logic [15:0] h);
		rise(h);
		h = 0;
		while (iclk === 1'b1 && h < 400) begin
			cyc_n(1);
			h++;
		end
	endtask
	// sync at a fixed phase of the raw clock so a taken one repeats exactly
	task automatic sync_at(output logic [15:0] d);
		repeat (5) @(posedge raw);
		cyc_n(1);
		syn = 1'b1;
		rise(d);
		syn = 1'b0;
	endtask
	task automatic wake_len(output logic [15:0] w);
		w = 0;
		while (busy !== 1'b1 && w < 20) begin
			cyc_n(1);
			w++;
		end
		while (busy === 1'b1 && w < 900) begin
			cyc_n(1);
			w++;
		end
	endtask
	function automatic logic [13:0] exp_fmt(input logic [13:0] x, int m);
		case (m)
			1, 5: return x ^ 14'h2000;
			2: return x ^ (x >> 1);
			default: return x;
		endcase
	endfunction
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(32'h4ee587e1));
		// the data source forks after seeding so it follows the seed
		fork
			forever @(negedge ref_clk) if (rnd) core <= 14'($urandom);
		join_none
		cyc_n(4);
		rst = 1'b0;
		for (int r = 0; r < 8; r++) begin
			ratio = 3'(r);
			cyc_n(80);
			rise(t);
			rise(t);
			chk(t, 16'(6 * (r + 1)));
			chk(16'(dact), 16'(r != 0));
		end
		$display("divider done");
		ratio = 3'h3;
		wr_reg(13'h100, 8'h02);
		sync_at(d1);
		sync_at(d1);
		sync_at(d2);
		chk(d2, d1);
		wr_reg(13'h100, 8'h06);
		rd_reg(13'h100, 8'h0E);
		sync_at(d2);
		chk(d2, d1);
		rd_reg(13'h100, 8'h06);
		sync_at(d2);
		chk(16'(d2 == d1), 16'h0000);
		wr_reg(13'h0FF, 8'hFF);
		rd_reg(13'h100, 8'h06);
		$display("sync done");
		ratio = 3'h0;
		dcs_en = 1'b1;
		cyc_n(640);
		chk(16'(lock), 16'h0001);
		hi_len(t);
		chk(t, 16'h0003);
		dcs_en = 1'b0;
		cyc_n(40);
		hi_len(t);
		chk(t, 16'h0002);
		per = 10;
		hi = 3;
		dcs_en = 1'b1;
		cyc_n(640);
		chk(16'(lock), 16'h0000);
		hi_len(t);
		chk(t, 16'h0003);
		ser = 1'b0;
		dcs_s = 1'b0;
		cyc_n(8);
		chk(16'(dact), 16'h0000);
		$display("stabilizer done");
		for (int i = 0; i < 6; i++) begin
			ser = 1'(i < 4);
			fmt = acdpc_fmt_t'(i[1:0]);
			fmt_s = i[0];
			cyc_n(5);
			chk(16'(dout), 16'(exp_fmt(core, i)));
		end
		rnd = 1'b0;
		cyc_n(1);
		core = 14'h2000;
		cyc_n(3);
		chk(16'(dout), 16'h0000);
		$display("format done");
		ser = 1'b1;
		pd = 1'b1;
		cyc_n(20);
		chk(16'(oe_n), 16'h0001);
		chk(16'(ref_on), 16'h0000);
		pd = 1'b0;
		wake_len(w1);
		pd = 1'b1;
		cyc_n(60);
		pd = 1'b0;
		wake_len(w2);
		chk(16'(w2 > w1), 16'h0001);
		cfg_sb = 1'b1;
		cyc_n(60);
		chk(16'(ref_on), 16'h0001);
		cfg_sb = 1'b0;
		wake_len(w1);
		chk(16'(w1 < w2), 16'h0001);
		cfg_pd = 1'b1;
		cyc_n(3);
		cfg_pd = 1'b0;
		wake_len(w1);
		chk(16'(oe_n), 16'h0000);
		$display("power done");
		wrap_up();
	end
endmodule
bind acdpc_top acdpc_assertions #(.DATA_WIDTH(DATA_WIDTH)) i_acdpc_assertions (
	.REF_CLK(REF_CLK), .RST(RST), .SERIAL_MODE(SERIAL_MODE),
	.REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
	.CFG_POWER_DOWN(CFG_POWER_DOWN), .CFG_FORMAT(CFG_FORMAT),
	.CFG_DIV_RATIO(CFG_DIV_RATIO), .CORE_DATA(CORE_DATA),
	.DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .DCS_ACTIVE(DCS_ACTIVE),
	.DCS_LOCKED(DCS_LOCKED), .REF_ON(REF_ON), .BIAS_ON(BIAS_ON),
	.CLK_RUN(CLK_RUN), .WAKE_BUSY(WAKE_BUSY));
